/* fifo_offset_parallel_access_tb_top.sv */
// Self-checking bench for the offset load and readback block.
// Assumes the design files and fop_map.svh are compiled first.
`include "fop_map.svh"
`timescale 1ns/1ps

module fifo_offset_parallel_access_tb_top;
  localparam int OFS_W = 17;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic part_rst_b = 1'b1;
  logic in_wide = 1'b0;
  logic out_wide = 1'b0;
  logic par_mode = 1'b1;
  logic sync_mode = 1'b1;
  logic ld_b, wr_en_b, rd_en_b, rd_seen, ae_vld, af_vld, mwr, mrd;
  logic [17:0] din, fword, dout;
  logic [OFS_W-1:0] eofs, fofs;
  int num_errors = 0;
  int total_checks = 0;
  logic [31:0] lfsr = 32'h0000_05e4;
  logic [17:0] exp_q[$];
  logic [3:0] cfgs[5] = '{4'b0011, 4'b1110, 4'b1011, 4'b0111, 4'b0001};

  always #12.5 ref_clk = ~ref_clk;

  fop_top #(.OFS_W(OFS_W), .DEPTH_CODE(`FOP_BIG_CODE)) dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .in_wide_strap(in_wide),
    .out_wide_strap(out_wide), .par_mode_strap(par_mode),
    .sync_flag_strap(sync_mode), .part_rst_b(part_rst_b),
    .offset_load_select_b(ld_b), .wr_en_b(wr_en_b), .rd_en_b(rd_en_b),
    .data_in_bus(din), .fifo_word(fword), .data_out_bus(dout),
    .empty_offset(eofs), .full_offset(fofs), .almost_empty_valid(ae_vld),
    .almost_full_valid(af_vld), .mem_wr_pulse(mwr), .mem_rd_pulse(mrd));

  fop_host host (.ref_clk(ref_clk), .offset_load_select_b(ld_b),
    .wr_en_b(wr_en_b), .rd_en_b(rd_en_b), .data_in_bus(din),
    .fifo_word(fword), .rd_seen(rd_seen));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input string what, input logic [26:0] seen,
                       input logic [26:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Every read result is compared with the oldest note.
  always @(negedge ref_clk) begin
    if (rd_seen && rst_b) begin
      if (exp_q.size() == 0) begin
        check("read without note", 27'h000_0001, 27'h000_0000);
      end else begin
        check("data_out_bus", 27'(dout), 27'(exp_q.pop_front()));
      end
    end
  end

  task automatic do_reset(input logic [3:0] cfg);
    rst_b <= 1'b0;
    {in_wide, out_wide, par_mode, sync_mode} <= cfg;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    check("empty_offset", 27'(eofs), `FOP_OFS_RST);
    check("full_offset", 27'(fofs), `FOP_OFS_RST);
  endtask

  // ****************************************
  // One configuration: load, wrap, read back
  // ****************************************
  task automatic run_cfg(input logic [3:0] cfg);
    logic iw, ow, par;
    int pin, pout, wi, k, o;
    logic [26:0] acc[2];
    logic [26:0] m, ofs;
    logic [17:0] v;
    iw = cfg[3];
    ow = cfg[2];
    par = cfg[1];
    pin = iw ? 1 : (ow ? 2 : 3);
    pout = ow ? 1 : (iw ? 2 : 3);
    wi = iw ? 18 : 9;
    m = iw ? 27'h003_FFFF : 27'h000_01FF;
    acc[0] = `FOP_OFS_RST;
    acc[1] = `FOP_OFS_RST;
    do_reset(cfg);
    for (int n = 0; n <= 2 * pin; n++) begin
      lfsr = lfsr_next(lfsr);
      v = 18'(27'(lfsr) & m);
      k = n % pin;
      o = (n / pin) % 2;
      if (par) begin
        acc[o] = (acc[o] & ~(m << (k * wi))) | (27'(v) << (k * wi));
      end
      host.op(3'h1, v);
      if (n == 0) begin
        #1;
        check("mem_wr_pulse", 27'(mwr), 27'h000_0000);
        host.op(3'h3, ~v);
        #1;
        check("mem_wr_pulse", 27'(mwr), 27'h000_0001);
        host.op(3'h0, v);
        #1;
        check("mem_wr_pulse", 27'(mwr), 27'h000_0000);
        check("almost_full_valid", 27'(af_vld), 27'(!par));
        check("almost_empty_valid", 27'(ae_vld), 27'(!par || iw));
      end
      if (n == 2 * pin - 1) begin
        repeat (3) host.op(3'h0, v);
        #1;
        check("almost_full_valid", 27'(af_vld), 27'h000_0001);
        check("almost_empty_valid", 27'(ae_vld), 27'h000_0001);
      end
    end
    host.op(3'h0, v);
    #1;
    check("empty_offset", 27'(eofs), acc[0] & 27'h001_FFFF);
    check("full_offset", 27'(fofs), acc[1] & 27'h001_FFFF);
    for (int n = 0; n <= 2 * pout; n++) begin
      k = n % pout;
      o = (n / pout) % 2;
      ofs = acc[o] & 27'h001_FFFF;
      exp_q.push_back(ow ? 18'(ofs) : 18'((ofs >> (9 * k)) & 27'h000_01FF));
      host.op(3'h2, 18'h0_0000);
      if (n == 0) begin
        lfsr = lfsr_next(lfsr);
        exp_q.push_back(lfsr[17:0]);
        host.op(3'h4, lfsr[17:0]);
        #1;
        check("mem_rd_pulse", 27'(mrd), 27'h000_0001);
      end
      if (n == 1) begin
        part_rst_b <= 1'b0;
        host.op(3'h0, 18'h0_0000);
        part_rst_b <= 1'b1;
        #1;
        check("data_out_bus", 27'(dout), 27'h000_0000);
      end
    end
    repeat (3) host.op(3'h0, 18'h0_0000);
    check("notes left", 27'(exp_q.size()), 27'h000_0000);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    conclude();
  end

  initial begin
    for (int i = 0; i < 5; i++) begin
      run_cfg(cfgs[i]);
    end
    conclude();
  end
endmodule // fifo_offset_parallel_access_tb_top

/* fop_host.sv */
// Host controller model driving the write and read ports of the offset block.
// Assumes every task call starts right after a rising edge of ref_clk.
`include "fop_map.svh"
`timescale 1ns/1ps

module fop_host (
  // Clock
  input wire logic ref_clk,
  // Host port
  output logic offset_load_select_b,
  output logic wr_en_b,
  output logic rd_en_b,
  output logic [`FOP_WIDE_W-1:0] data_in_bus,
  output logic [`FOP_WIDE_W-1:0] fifo_word,
  // High in the cycle after an edge that took a read
  output logic rd_seen
);
  initial begin
    offset_load_select_b = 1'b1;
    wr_en_b = 1'b1;
    rd_en_b = 1'b1;
    data_in_bus = 18'h0_0000;
    fifo_word = 18'h0_0000;
  end

  always @(posedge ref_clk) begin
    rd_seen <= !rd_en_b;
  end

  // Kinds: 0 idle, 1 offset write, 2 offset read, 3 memory write, 4 memory
  // read. One kind a cycle, so an offset read never meets an offset write.
  // Idle buses carry the inverse of their last value.
  task automatic op(input logic [2:0] kind, input logic [17:0] d);
    offset_load_select_b <= !(kind == 3'h1 || kind == 3'h2);
    wr_en_b <= !(kind == 3'h1 || kind == 3'h3);
    rd_en_b <= !(kind == 3'h2 || kind == 3'h4);
    data_in_bus <= (kind == 3'h1 || kind == 3'h3) ? d : ~data_in_bus;
    fifo_word <= (kind == 3'h4) ? d : ~fifo_word;
    @(posedge ref_clk);
  endtask
endmodule // fop_host

/* fop_map.svh */
// Offset positions, reset values and timing counts of the offset block.
// Assumes inclusion by the package and by every design module that needs it.
`ifndef FOP_MAP_SVH
`define FOP_MAP_SVH

// Port widths in bits.
`define FOP_WIDE_W 18
`define FOP_NARROW_W 9
// Widest offset that the storage can hold.
`define FOP_OFS_MAX 27
// Offset value held from master reset until software loads its own.
`define FOP_OFS_RST 27'h000_007F
// Pointer width and the position of the empty offset low part.
`define FOP_PTR_W 3
`define FOP_PTR_FIRST 3'h0
// Depth code of the largest variant.
`define FOP_BIG_CODE 2'h3
// Clock period in ns and the flag settling time in write-clock edges.
`define FOP_CLK_NS 25
`define FOP_SETTLE 2
`define FOP_SETTLE_CNT 2'h1

`endif

/* fop_ofs_rd.sv */
// Read offset pointer and the output data register.
// Assumes rd_ofs and mem_rd are never high together.
`include "fop_map.svh"
`timescale 1ns/1ps

module fop_ofs_rd (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_sync_b,
  input wire logic part_rst_b,
  // Control
  input wire logic rd_ofs,
  input wire logic mem_rd,
  input wire logic wide,
  input wire logic [1:0] parts,
  // Sources
  input wire logic [`FOP_OFS_MAX-1:0] empty_offset,
  input wire logic [`FOP_OFS_MAX-1:0] full_offset,
  input wire logic [`FOP_WIDE_W-1:0] fifo_word,
  // State
  output logic [`FOP_PTR_W-1:0] rd_ptr,
  output logic [`FOP_WIDE_W-1:0] data_out_bus
);

  fop_pkg::fop_rd_st_t st_r;
  fop_pkg::fop_rd_st_t st_nxt;

  always_comb begin
    logic sel_f;
    logic [`FOP_PTR_W-1:0] part;
    logic [`FOP_OFS_MAX-1:0] src;
    sel_f = st_r.ptr >= {1'b0, parts};
    part = sel_f ? st_r.ptr - {1'b0, parts} : st_r.ptr;
    src = sel_f ? full_offset : empty_offset;
    src = wide ? src : src >> (5'(part) * 5'h9);
    st_nxt = st_r;
    if (!part_rst_b) begin
      st_nxt.q = '0;
    end else if (mem_rd) begin
      st_nxt.q = fifo_word;
    end else if (rd_ofs) begin
      st_nxt.q = wide ? src[`FOP_WIDE_W-1:0]
                      : {9'h000, src[`FOP_NARROW_W-1:0]};
    end
    // The pointer moves on every offset read, partial reset or not.
    if (rd_ofs) begin
      if (st_r.ptr == fop_pkg::fop_last_f(parts)) begin
        st_nxt.ptr = `FOP_PTR_FIRST;
      end else begin
        st_nxt.ptr = st_r.ptr + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r <= '{ptr: `FOP_PTR_FIRST, q: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_ptr = st_r.ptr;
  assign data_out_bus = st_r.q;

endmodule // fop_ofs_rd

/* fop_ofs_wr.sv */
// Write offset pointer and the empty and full offset storage.
// Assumes wr_ofs is already qualified by load select and write enable.
`include "fop_map.svh"
`timescale 1ns/1ps

module fop_ofs_wr (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_sync_b,
  // Control
  input wire logic wr_ofs,
  input wire logic wide,
  input wire logic [1:0] parts,
  input wire logic [`FOP_WIDE_W-1:0] data_in_bus,
  // State
  output logic [`FOP_PTR_W-1:0] wr_ptr,
  output logic [`FOP_OFS_MAX-1:0] empty_offset,
  output logic [`FOP_OFS_MAX-1:0] full_offset,
  output logic done_e,
  output logic done_f
);

  fop_pkg::fop_wr_st_t st_r;
  fop_pkg::fop_wr_st_t st_nxt;

  always_comb begin
    int lo;
    int w;
    logic sel_f;
    logic [`FOP_PTR_W-1:0] part;
    logic [`FOP_OFS_MAX-1:0] val;
    lo = 0;
    w = wide ? `FOP_WIDE_W : `FOP_NARROW_W;
    sel_f = st_r.ptr >= {1'b0, parts};
    part = sel_f ? st_r.ptr - {1'b0, parts} : st_r.ptr;
    val = sel_f ? st_r.ofs_f : st_r.ofs_e;
    st_nxt = st_r;
    st_nxt.done_e = 1'b0;
    st_nxt.done_f = 1'b0;
    if (wr_ofs) begin
      lo = int'(part) * w;
      for (int i = 0; i < `FOP_OFS_MAX; i++) begin
        if (i >= lo && i < lo + w) begin
          val[i] = data_in_bus[i - lo];
        end
      end
      if (sel_f) begin
        st_nxt.ofs_f = val;
        st_nxt.done_f = part == 3'({1'b0, parts}) - 3'h1;
      end else begin
        st_nxt.ofs_e = val;
        st_nxt.done_e = part == 3'({1'b0, parts}) - 3'h1;
      end
      if (st_r.ptr == fop_pkg::fop_last_f(parts)) begin
        st_nxt.ptr = `FOP_PTR_FIRST;
      end else begin
        st_nxt.ptr = st_r.ptr + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r <= '{ptr: `FOP_PTR_FIRST, ofs_e: `FOP_OFS_RST,
                ofs_f: `FOP_OFS_RST, done_e: 1'b0, done_f: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wr_ptr = st_r.ptr;
  assign empty_offset = st_r.ofs_e;
  assign full_offset = st_r.ofs_f;
  assign done_e = st_r.done_e;
  assign done_f = st_r.done_f;

endmodule // fop_ofs_wr

/* fop_pkg.sv */
// Types and the part-count arithmetic shared by the offset block.
// Assumes fop_map.svh is on the include path.
`include "fop_map.svh"

package fop_pkg;

  typedef struct packed {
    logic [`FOP_PTR_W-1:0] ptr;
    logic [`FOP_OFS_MAX-1:0] ofs_e;
    logic [`FOP_OFS_MAX-1:0] ofs_f;
    logic done_e;
    logic done_f;
  } fop_wr_st_t;

  typedef struct packed {
    logic [`FOP_PTR_W-1:0] ptr;
    logic [`FOP_WIDE_W-1:0] q;
  } fop_rd_st_t;

  typedef struct packed {
    logic cap_done;
    logic in_wide;
    logic out_wide;
    logic par_mode;
    logic sync_mode;
    logic ae_vld;
    logic af_vld;
    logic [1:0] ae_cnt;
    logic [1:0] af_cnt;
    logic mem_wr;
    logic mem_rd;
  } fop_top_st_t;

  // Parts per offset seen from one port, given both port widths.
  function automatic logic [1:0] fop_parts_f(input logic wide,
                                             input logic other_wide,
                                             input logic big);
    if (wide) begin
      return 2'h1;
    end else if (!other_wide && big) begin
      return 2'h3;
    end
    return 2'h2;
  endfunction

  // Last pointer position of a full pass over both offsets.
  function automatic logic [`FOP_PTR_W-1:0] fop_last_f(
      input logic [1:0] parts);
    return 3'({parts, 1'b0}) - 3'h1;
  endfunction

endpackage

/* fop_top.sv */
// Parallel load and readback of the programmable flag offsets.
// Assumes all host inputs are synchronous to ref_clk, which serves as both
// the write clock and the read clock; rst_b is the master reset.
//
// Implementation choices: the address map and strobed register access.
`include "fop_map.svh"
`timescale 1ns/1ps

module fop_top #(
  parameter int OFS_W = 17,
  parameter logic [1:0] DEPTH_CODE = `FOP_BIG_CODE
) (
  // Clock and master reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Configuration straps, caught once after master reset
  input wire logic in_wide_strap,
  input wire logic out_wide_strap,
  input wire logic par_mode_strap,
  input wire logic sync_flag_strap,
  // Partial reset
  input wire logic part_rst_b,
  // Host write and read ports
  input wire logic offset_load_select_b,
  input wire logic wr_en_b,
  input wire logic rd_en_b,
  input wire logic [`FOP_WIDE_W-1:0] data_in_bus,
  input wire logic [`FOP_WIDE_W-1:0] fifo_word,
  // Offsets and output data
  output logic [`FOP_WIDE_W-1:0] data_out_bus,
  output logic [OFS_W-1:0] empty_offset,
  output logic [OFS_W-1:0] full_offset,
  // Flag validity and memory strobes
  output logic almost_empty_valid,
  output logic almost_full_valid,
  output logic mem_wr_pulse,
  output logic mem_rd_pulse
);

  // ***************************************************************
  // Parameter checks
  // ***************************************************************

  if (OFS_W < `FOP_NARROW_W || OFS_W > `FOP_OFS_MAX) begin : g_ofs_chk
    $error("OFS_W must lie between 9 and 27.");
  end

  // ***************************************************************
  // Reset synchroniser
  // ***************************************************************

  logic [1:0] rst_sync_r;
  logic rst_sync_b;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_sync_b = rst_sync_r[1];

  // ***************************************************************
  // Control state
  // ***************************************************************

  fop_pkg::fop_top_st_t st_r;
  fop_pkg::fop_top_st_t st_nxt;

  logic big;
  logic [1:0] wr_parts;
  logic [1:0] rd_parts;
  logic wr_ofs;
  logic rd_ofs;
  logic wr_start;
  logic [`FOP_PTR_W-1:0] wr_ptr;
  logic [`FOP_PTR_W-1:0] rd_ptr;
  logic [`FOP_OFS_MAX-1:0] ofs_e;
  logic [`FOP_OFS_MAX-1:0] ofs_f;
  logic done_e;
  logic done_f;
  logic [`FOP_OFS_MAX-1:0] rd_ofs_e;
  logic [`FOP_OFS_MAX-1:0] rd_ofs_f;

  assign big = DEPTH_CODE == `FOP_BIG_CODE;
  assign wr_parts = fop_pkg::fop_parts_f(st_r.in_wide, st_r.out_wide,
                                         big);
  assign rd_parts = fop_pkg::fop_parts_f(st_r.out_wide, st_r.in_wide,
                                         big);

  // Offset writes need the parallel method; reads do not.
  assign wr_ofs = st_r.cap_done && st_r.par_mode && !offset_load_select_b
                  && !wr_en_b;
  assign rd_ofs = st_r.cap_done && !offset_load_select_b
                  && !rd_en_b;
  assign wr_start = wr_ofs && wr_ptr == `FOP_PTR_FIRST;

  always_comb begin
    st_nxt = st_r;
    if (!st_r.cap_done) begin
      st_nxt.cap_done = 1'b1;
      st_nxt.in_wide = in_wide_strap;
      st_nxt.out_wide = out_wide_strap;
      st_nxt.par_mode = par_mode_strap;
      st_nxt.sync_mode = sync_flag_strap;
    end
    st_nxt.mem_wr = st_r.cap_done && offset_load_select_b
                    && !wr_en_b;
    st_nxt.mem_rd = st_r.cap_done && offset_load_select_b
                    && !rd_en_b;
    // Almost full settles on the write clock.
    if (st_r.af_cnt != 2'h0) begin
      st_nxt.af_cnt = st_r.af_cnt - 2'h1;
      st_nxt.af_vld = st_r.af_cnt == `FOP_SETTLE_CNT;
    end
    if (done_f) begin
      st_nxt.af_cnt = `FOP_SETTLE_CNT;
    end
    // Almost empty settles on the read clock when synchronous.
    if (st_r.ae_cnt != 2'h0) begin
      st_nxt.ae_cnt = st_r.ae_cnt - 2'h1;
      st_nxt.ae_vld = st_r.ae_cnt == `FOP_SETTLE_CNT;
    end
    if (done_e) begin
      if (st_r.sync_mode) begin
        st_nxt.ae_cnt = `FOP_SETTLE_CNT;
      end else begin
        st_nxt.ae_vld = 1'b1;
      end
    end
    if (wr_start) begin
      st_nxt.ae_vld = 1'b0;
      st_nxt.af_vld = 1'b0;
      st_nxt.ae_cnt = 2'h0;
      st_nxt.af_cnt = 2'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r <= '{cap_done: 1'b0, in_wide: 1'b0, out_wide: 1'b0,
                par_mode: 1'b0, sync_mode: 1'b0, ae_vld: 1'b1,
                af_vld: 1'b1, ae_cnt: 2'h0, af_cnt: 2'h0,
                mem_wr: 1'b0, mem_rd: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ***************************************************************
  // Offset pointers and storage
  // ***************************************************************

  // Offset bits above OFS_W are dropped, so readback shows them as zero.
  localparam logic [`FOP_OFS_MAX-1:0] OFS_MASK =
    {`FOP_OFS_MAX{1'b1}} >> (`FOP_OFS_MAX - OFS_W);

  assign rd_ofs_e = ofs_e & OFS_MASK;
  assign rd_ofs_f = ofs_f & OFS_MASK;

  // Partial reset reaches neither pointer.
  fop_ofs_wr u_wr (
    .ref_clk(ref_clk),
    .rst_sync_b(rst_sync_b),
    .wr_ofs(wr_ofs),
    .wide(st_r.in_wide),
    .parts(wr_parts),
    .data_in_bus(data_in_bus),
    .wr_ptr(wr_ptr),
    .empty_offset(ofs_e),
    .full_offset(ofs_f),
    .done_e(done_e),
    .done_f(done_f)
  );

  fop_ofs_rd u_rd (
    .ref_clk(ref_clk),
    .rst_sync_b(rst_sync_b),
    .part_rst_b(part_rst_b),
    .rd_ofs(rd_ofs),
    .mem_rd(st_nxt.mem_rd),
    .wide(st_r.out_wide),
    .parts(rd_parts),
    .empty_offset(rd_ofs_e),
    .full_offset(rd_ofs_f),
    .fifo_word(fifo_word),
    .rd_ptr(rd_ptr),
    .data_out_bus(data_out_bus)
  );

  assign empty_offset = ofs_e[OFS_W-1:0];
  assign full_offset = ofs_f[OFS_W-1:0];
  assign almost_empty_valid = st_r.ae_vld;
  assign almost_full_valid = st_r.af_vld;
  assign mem_wr_pulse = st_r.mem_wr;
  assign mem_rd_pulse = st_r.mem_rd;

  // ***************************************************************
  // Assertions
  // ***************************************************************

  default clocking cb @(posedge ref_clk);
  endclocking

  default disable iff (!rst_sync_b);

  wr_advance_a: assert property (
    wr_ofs && wr_ptr != fop_pkg::fop_last_f(wr_parts)
    |=> wr_ptr == $past(wr_ptr) + 3'h1)
    else $error("Write pointer did not advance.");

  wr_wrap_a: assert property (
    wr_ofs && wr_ptr == fop_pkg::fop_last_f(wr_parts)
    |=> wr_ptr == `FOP_PTR_FIRST)
    else $error("Write pointer did not wrap.");

  wr_hold_a: assert property (
    !wr_ofs |=> $stable(wr_ptr))
    else $error("Write pointer moved without a load.");

  rd_indep_a: assert property (
    wr_ofs && !rd_ofs |=> $stable(rd_ptr))
    else $error("Read pointer moved on an offset write.");

  rd_wrap_a: assert property (
    rd_ofs && rd_ptr == fop_pkg::fop_last_f(rd_parts)
    |=> rd_ptr == `FOP_PTR_FIRST)
    else $error("Read pointer did not wrap.");

  rd_data_a: assert property (
    rd_ofs && rd_ptr == `FOP_PTR_FIRST && st_r.out_wide && part_rst_b
    |=> data_out_bus == $past(rd_ofs_e[`FOP_WIDE_W-1:0]))
    else $error("Empty offset not driven on readback.");

  part_rst_a: assert property (
    !part_rst_b && !wr_ofs && !rd_ofs
    |=> $stable(wr_ptr) && $stable(rd_ptr))
    else $error("Partial reset moved an offset pointer.");

  start_inval_a: assert property (
    wr_start |=> !almost_empty_valid && !almost_full_valid)
    else $error("Flags stayed valid at programming start.");

  af_settle_a: assert property (
    done_f && !wr_start ##1 !wr_start |=> almost_full_valid)
    else $error("Almost full not valid two edges after load.");

  af_early_a: assert property (
    done_f && !wr_start |=> !almost_full_valid)
    else $error("Almost full valid too early.");

  ae_settle_a: assert property (
    done_e && st_r.sync_mode ##1 !wr_start |=> almost_empty_valid)
    else $error("Almost empty not valid two edges after load.");

  mem_split_a: assert property (
    !offset_load_select_b |=> !mem_wr_pulse && !mem_rd_pulse)
    else $error("Offset cycle counted as a memory access.");

  serial_lock_a: assert property (
    st_r.cap_done && !st_r.par_mode |=> $stable(wr_ptr))
    else $error("Offset written under the serial method.");

  ae_async_a: assert property (
    done_e && !st_r.sync_mode && !wr_start |=> almost_empty_valid)
    else $error("Almost empty not valid one edge after load.");

  rd_advance_a: assert property (
    rd_ofs && rd_ptr != fop_pkg::fop_last_f(rd_parts)
    |=> rd_ptr == $past(rd_ptr) + 3'h1)
    else $error("Read pointer did not advance.");

  rd_hold_a: assert property (
    !rd_ofs |=> $stable(rd_ptr))
    else $error("Read pointer moved without an offset read.");

  rd_narrow_a: assert property (
    rd_ofs && !st_r.out_wide && part_rst_b
    |=> data_out_bus[`FOP_WIDE_W-1:`FOP_NARROW_W] == 9'h000)
    else $error("Upper output bits not zero on narrow readback.");

  rd_full_a: assert property (
    rd_ofs && rd_ptr == {1'b0, rd_parts} && st_r.out_wide && part_rst_b
    |=> data_out_bus == $past(rd_ofs_f[`FOP_WIDE_W-1:0]))
    else $error("Full offset not driven on readback.");

  mem_word_a: assert property (
    st_r.cap_done && offset_load_select_b && !rd_en_b && part_rst_b
    |=> data_out_bus == $past(fifo_word))
    else $error("Memory word not loaded on a memory read.");

  mem_wr_a: assert property (
    st_r.cap_done && offset_load_select_b && !wr_en_b |=> mem_wr_pulse)
    else $error("Memory write not signalled.");

  part_clr_a: assert property (
    !part_rst_b |=> data_out_bus == '0)
    else $error("Partial reset left data on the output bus.");

  // ***************************************************************
  // Cover properties
  // ***************************************************************

  full_load_c: cover property (
    wr_ofs && wr_ptr == fop_pkg::fop_last_f(wr_parts) ##3 almost_full_valid);

  resume_c: cover property (
    wr_ofs ##1 offset_load_select_b && !wr_en_b ##1 wr_ofs);

  rd_wrap_c: cover property (
    rd_ofs && rd_ptr == fop_pkg::fop_last_f(rd_parts) ##1 rd_ofs);

  serial_rd_c: cover property (
    rd_ofs && !st_r.par_mode);

  ae_async_c: cover property (
    done_e && !st_r.sync_mode ##1 almost_empty_valid);

endmodule // fop_top
